// File: rtl/rci_pkg.sv
// Shared constants and types for the radio two-wire command port
package rci_pkg;

    // Core clock rate used to turn times into cycle counts
    localparam int CLK_MHZ = 200;

    // Fixed upper part of the 7-bit slave address
    localparam logic [4:0] ADDR_FIXED = 5'h19;

    // Typical command times, as printed
    localparam int WAKE_FM_US = 3000;
    localparam int WAKE_DAB_US = 3200;
    localparam int LAUNCH_FM_MS = 63;
    localparam int LAUNCH_DAB_MS = 269;
    // Derived cycle counts (default values of top-level parameters)
    localparam int WAKE_FM_CYC = WAKE_FM_US * CLK_MHZ;
    localparam int WAKE_DAB_CYC = WAKE_DAB_US * CLK_MHZ;
    localparam int LAUNCH_FM_CYC = LAUNCH_FM_MS * 1000 * CLK_MHZ;
    localparam int LAUNCH_DAB_CYC = LAUNCH_DAB_MS * 1000 * CLK_MHZ;
    // Execution time of any other command
    localparam int GENERIC_CYC = 16;

    // Command codes (values are arbitrary)
    localparam logic [7:0] OP_WAKE = 8'h10;
    localparam logic [7:0] OP_LOAD = 8'h11;
    localparam logic [7:0] OP_LAUNCH = 8'h12;

    // Synchroniser lanes and their reset values
    localparam int SYN_SCL = 0;
    localparam int SYN_SDA = 1;
    localparam int SYN_RST = 2;
    localparam int SYN_MODE = 3;
    localparam int SYN_SS = 4;
    localparam int SYN_MISO = 5;
    localparam int SYN_RXT = 6;
    localparam int SYN_W = 7;
    localparam logic [SYN_W-1:0] SYN_RESET_VAL = 7'h03;

    // Response layout
    localparam int RESP_BYTES = 4;
    localparam int CTS_BIT = 7;
    localparam int ERR_BIT = 6;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Power states
    typedef enum logic [2:0] {
        PS_RESET = 3'b001,
        PS_STARTUP = 3'b010,
        PS_OPER = 3'b100
    } rci_pwr_type;

    // Link-side transaction states
    typedef enum logic [3:0] {
        LS_ADDR = 4'b0001,
        LS_WR = 4'b0010,
        LS_RD = 4'b0100,
        LS_SKIP = 4'b1000
    } rci_link_type;

    // Response bytes in the order they go out
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] state;
        logic [7:0] last_cmd;
        logic [7:0] arg_count;
    } rci_resp_type;

endpackage

// File: rtl/rci_port.sv
// Two-wire command port with power-state control for a radio receiver
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Strap high selects two-wire control mode
// - 7-bit addressing, serial clock up to 400 kHz
// - Every transfer is one eight-bit byte
// - Clock from clock pin, data on data pin
// - Address is 11001 plus two strap bits
// - Bit 0 from data-out pin, bit 1 from select
// - Control byte: address then direction, sampled rising
// - Matching control byte acknowledged from next falling edge
// - Write bytes sampled rising, acknowledged one cycle
// - First written byte is command, rest arguments
// - Read bytes go out MSB first after falling
// - Missing host acknowledge ends the read
// - Reads return the last command's response
// - Status leads response; clear-to-send flag first
// - Reset pin low keeps everything disabled
// - Reset release enters startup, wake and load
// - Launch enters operational; reset pin returns anywhere
// - Wake takes 3 ms analog, 3.2 ms digital
// - Launch takes 63 ms analog, 269 ms digital
// - Strap low selects the other control mode; here it only turns the two-wire port off
module rci_port #(
    parameter int unsigned WAKE_FM_CYC = rci_pkg::WAKE_FM_CYC,
    parameter int unsigned WAKE_DAB_CYC = rci_pkg::WAKE_DAB_CYC,
    parameter int unsigned LAUNCH_FM_CYC = rci_pkg::LAUNCH_FM_CYC,
    parameter int unsigned LAUNCH_DAB_CYC = rci_pkg::LAUNCH_DAB_CYC
) (
    input wire logic core_clk, // Core clock, 200 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic scl_clk, // Serial clock from the clock pin
    input wire logic sda_in, // Serial data pin level
    output logic sda_out, // Serial data drive value, always low
    output logic sda_oe, // Pull serial data low when high
    input wire logic chip_reset_n, // Device reset pin, active low
    input wire logic interface_select_strap, // High selects two-wire
    input wire logic slave_select_pin_n, // Address strap, high bit
    input wire logic miso_strap_in, // Address strap, low bit
    input wire logic digital_mode, // High for digital broadcast timing
    output rci_pkg::rci_pwr_type power_state, // Current power state
    output logic two_wire_mode, // Two-wire control selected
    output logic cmd_busy // A command is executing
);

    // ---------------- Core domain ----------------
    logic [rci_pkg::SYN_W-1:0] syn1_q;
    logic [rci_pkg::SYN_W-1:0] syn2_q;
    logic [rci_pkg::SYN_W-1:0] syn3_q;
    logic [rci_pkg::SYN_W-1:0] filt_q;
    logic [rci_pkg::SYN_W-1:0] raw_pins;
    logic scl_prev_q;
    logic sda_prev_q;
    logic rxt_prev_q;
    logic start_ev;
    logic stop_ev;
    logic rx_ev;
    logic start_hold_q;
    logic frame_q;
    logic link_rst_n_q;
    logic port_en;
    rci_pkg::rci_pwr_type pwr_q;
    logic mode_q;
    logic addr_strap_bit_hi;
    logic addr_strap_bit_lo;
    logic [7:0] cmd_q;
    logic [7:0] argc_q;
    logic [7:0] wr_cnt_q;
    logic cts_q;
    logic err_q;
    logic busy_q;
    logic launch_q;
    logic [31:0] tmr_q;
    rci_pkg::rci_resp_type resp_q;
    // ---------------- Link domain ----------------
    rci_pkg::rci_link_type lst_q;
    logic [3:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic ack_q;
    logic [2:0] rd_idx_q;
    logic [7:0] rx_byte_q;
    logic rx_tgl_q;
    logic [7:0] tx_byte;
    logic sda_oe_q;
    logic sda_out_q;

    // Picks one response byte; bytes past the arg_count field read zero
    function automatic logic [7:0] resp_byte(
        input rci_pkg::rci_resp_type r,
        input logic [2:0] idx
    );
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            3'h0: b = r.status;
            3'h1: b = r.state;
            3'h2: b = r.last_cmd;
            3'h3: b = r.arg_count;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // Busy time of an accepted command, by opcode and timing set
    function automatic logic [31:0] exec_cycles(
        input logic [7:0] op,
        input logic digital
    );
        logic [31:0] c;
        c = 32'(rci_pkg::GENERIC_CYC);
        if (op == rci_pkg::OP_WAKE) begin
            c = digital ? 32'(WAKE_DAB_CYC) : 32'(WAKE_FM_CYC);
        end else if (op == rci_pkg::OP_LAUNCH) begin
            c = digital ? 32'(LAUNCH_DAB_CYC) : 32'(LAUNCH_FM_CYC);
        end
        return c;
    endfunction

    // Pins and the link-side byte toggle enter the core domain
    assign raw_pins = {rx_tgl_q, miso_strap_in, slave_select_pin_n,
                       interface_select_strap, chip_reset_n, sda_in,
                       scl_clk};

    // Three-stage synchroniser; a level counts once stages 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < rci_pkg::SYN_W; gi++) begin : g_sync
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    syn1_q[gi] <= rci_pkg::SYN_RESET_VAL[gi];
                    syn2_q[gi] <= rci_pkg::SYN_RESET_VAL[gi];
                    syn3_q[gi] <= rci_pkg::SYN_RESET_VAL[gi];
                    filt_q[gi] <= rci_pkg::SYN_RESET_VAL[gi];
                end else begin
                    syn1_q[gi] <= raw_pins[gi];
                    syn2_q[gi] <= syn1_q[gi];
                    syn3_q[gi] <= syn2_q[gi];
                    if (syn2_q[gi] == syn3_q[gi]) begin
                        filt_q[gi] <= syn3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // Previous filtered levels for edge detection
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            rxt_prev_q <= 1'b0;
        end else begin
            scl_prev_q <= filt_q[rci_pkg::SYN_SCL];
            sda_prev_q <= filt_q[rci_pkg::SYN_SDA];
            rxt_prev_q <= filt_q[rci_pkg::SYN_RXT];
        end
    end

    // Start: data falls with clock high; stop: data rises with clock high
    assign start_ev = filt_q[rci_pkg::SYN_SCL] & scl_prev_q &
                      sda_prev_q & ~filt_q[rci_pkg::SYN_SDA];
    assign stop_ev = filt_q[rci_pkg::SYN_SCL] & scl_prev_q &
                     ~sda_prev_q & filt_q[rci_pkg::SYN_SDA];
    assign rx_ev = filt_q[rci_pkg::SYN_RXT] ^ rxt_prev_q;
    assign port_en = mode_q & (pwr_q != rci_pkg::PS_RESET);

    // Frame tracking; the link logic runs only inside a frame
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            start_hold_q <= 1'b0;
            frame_q <= 1'b0;
            link_rst_n_q <= 1'b0;
        end else begin
            if (start_ev) begin
                start_hold_q <= 1'b1;
            end else if (!filt_q[rci_pkg::SYN_SCL]) begin
                start_hold_q <= 1'b0;
            end
            if (start_ev) begin
                frame_q <= 1'b1;
            end else if (stop_ev) begin
                frame_q <= 1'b0;
            end
            // Released once the clock has gone low after a start
            link_rst_n_q <= frame_q & ~start_hold_q & ~start_ev &
                            ~stop_ev & port_en;
        end
    end

    // Straps are followed while in reset and held afterwards
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= 1'b0;
            addr_strap_bit_hi <= 1'b0;
            addr_strap_bit_lo <= 1'b0;
        end else if (pwr_q == rci_pkg::PS_RESET) begin
            mode_q <= filt_q[rci_pkg::SYN_MODE];
            addr_strap_bit_hi <= filt_q[rci_pkg::SYN_SS];
            addr_strap_bit_lo <= filt_q[rci_pkg::SYN_MISO];
        end
    end

    // Written bytes: first is the command, the rest are arguments
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_cnt_q <= 8'h00;
            cmd_q <= 8'h00;
            argc_q <= 8'h00;
        end else if (start_ev) begin
            wr_cnt_q <= 8'h00;
        end else if (rx_ev && cts_q) begin
            if (wr_cnt_q == 8'h00) begin
                cmd_q <= rx_byte_q;
                argc_q <= 8'h00;
            end else if (argc_q != 8'hff) begin
                argc_q <= argc_q + 8'h01;
            end
            if (wr_cnt_q != 8'hff) begin
                wr_cnt_q <= wr_cnt_q + 8'h01;
            end
        end
    end

    // Power states and command execution with clear-to-send
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_q <= rci_pkg::PS_RESET;
            cts_q <= 1'b1;
            err_q <= 1'b0;
            busy_q <= 1'b0;
            launch_q <= 1'b0;
            tmr_q <= 32'h0000_0000;
        end else if (!filt_q[rci_pkg::SYN_RST]) begin
            pwr_q <= rci_pkg::PS_RESET;
            cts_q <= 1'b1;
            err_q <= 1'b0;
            busy_q <= 1'b0;
            launch_q <= 1'b0;
            tmr_q <= 32'h0000_0000;
        end else if (pwr_q == rci_pkg::PS_RESET) begin
            pwr_q <= rci_pkg::PS_STARTUP;
        end else if (busy_q) begin
            if (tmr_q <= 32'h0000_0001) begin
                busy_q <= 1'b0;
                cts_q <= 1'b1;
                if (launch_q) begin
                    pwr_q <= rci_pkg::PS_OPER;
                end
                launch_q <= 1'b0;
            end else begin
                tmr_q <= tmr_q - 32'h0000_0001;
            end
        end else if ((start_ev || stop_ev) && frame_q &&
                     wr_cnt_q != 8'h00 && cts_q) begin
            // Command complete at end of its write frame
            cts_q <= 1'b0;
            busy_q <= 1'b1;
            err_q <= 1'b0;
            tmr_q <= exec_cycles(cmd_q, digital_mode);
            if (pwr_q == rci_pkg::PS_STARTUP) begin
                // Startup takes only wake, load and launch
                if (cmd_q == rci_pkg::OP_LAUNCH) begin
                    launch_q <= 1'b1;
                end else if (cmd_q != rci_pkg::OP_WAKE &&
                             cmd_q != rci_pkg::OP_LOAD) begin
                    err_q <= 1'b1;
                    tmr_q <= 32'(rci_pkg::GENERIC_CYC);
                end
            end else if (cmd_q == rci_pkg::OP_WAKE ||
                         cmd_q == rci_pkg::OP_LAUNCH) begin
                err_q <= 1'b1;
                tmr_q <= 32'(rci_pkg::GENERIC_CYC);
            end
        end
    end

    // Response snapshot; frozen while a frame is open for a clean crossing
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            resp_q <= '0;
        end else if (!frame_q && !start_ev) begin
            resp_q.status <= {cts_q, err_q, 6'h00};
            resp_q.state <= {5'h00, pwr_q};
            resp_q.last_cmd <= cmd_q;
            resp_q.arg_count <= argc_q;
        end
    end

    // Status outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            power_state <= rci_pkg::PS_RESET;
            two_wire_mode <= 1'b0;
            cmd_busy <= 1'b0;
        end else begin
            power_state <= pwr_q;
            two_wire_mode <= mode_q;
            cmd_busy <= busy_q;
        end
    end

    // ---------------- Link domain logic on the serial clock ----------

    // Byte framing and address match, sampled on rising edges
    always_ff @(posedge scl_clk or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            lst_q <= rci_pkg::LS_ADDR;
            bit_cnt_q <= 4'h0;
            shift_q <= 7'h00;
            ack_q <= 1'b0;
            rd_idx_q <= 3'h0;
        end else if (bit_cnt_q == rci_pkg::BYTE_BITS) begin
            // Ninth clock: acknowledge slot
            bit_cnt_q <= 4'h0;
            ack_q <= 1'b0;
            if (lst_q == rci_pkg::LS_RD && !ack_q) begin
                if (sda_in) begin
                    lst_q <= rci_pkg::LS_SKIP;
                end else if (rd_idx_q != 3'(rci_pkg::RESP_BYTES)) begin
                    rd_idx_q <= rd_idx_q + 3'h1;
                end
            end
        end else begin
            shift_q <= {shift_q[5:0], sda_in};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == rci_pkg::BYTE_BITS - 4'h1) begin
                unique case (lst_q)
                    rci_pkg::LS_ADDR: begin
                        if (shift_q == {rci_pkg::ADDR_FIXED,
                                        addr_strap_bit_hi,
                                        addr_strap_bit_lo}) begin
                            ack_q <= 1'b1;
                            lst_q <= sda_in ? rci_pkg::LS_RD
                                            : rci_pkg::LS_WR;
                        end else begin
                            lst_q <= rci_pkg::LS_SKIP;
                        end
                    end
                    rci_pkg::LS_WR: ack_q <= 1'b1;
                    rci_pkg::LS_RD: ack_q <= 1'b0;
                    rci_pkg::LS_SKIP: ack_q <= 1'b0;
                endcase
            end
        end
    end

    // Received write byte handed to the core by a toggle
    always_ff @(posedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            rx_byte_q <= 8'h00;
            rx_tgl_q <= 1'b0;
        end else if (link_rst_n_q && lst_q == rci_pkg::LS_WR &&
                     bit_cnt_q == rci_pkg::BYTE_BITS - 4'h1) begin
            rx_byte_q <= {shift_q, sda_in};
            rx_tgl_q <= ~rx_tgl_q;
        end
    end

    assign tx_byte = resp_byte(resp_q, rd_idx_q);

    // Data drive changes only on falling edges
    always_ff @(negedge scl_clk or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            sda_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
            if (bit_cnt_q == rci_pkg::BYTE_BITS) begin
                sda_oe_q <= ack_q;
            end else if (lst_q == rci_pkg::LS_RD) begin
                // Most significant bit first; a zero pulls low
                sda_oe_q <= ~tx_byte[3'(3'h7 - bit_cnt_q[2:0])];
            end else begin
                sda_oe_q <= 1'b0;
            end
        end
    end

    assign sda_oe = sda_oe_q;
    assign sda_out = sda_out_q;

endmodule

`default_nettype wire

// File: testbench/rci_port_sva.sv
// Pin-level checks on the two-wire command port
`timescale 1ns/1ps
`default_nettype none
module rci_port_sva #(
    parameter int unsigned LAUNCH_DAB_CYC = 60
) (
    input wire logic core_clk, // Core clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic sda_out, // Data drive value
    input wire logic sda_oe, // Data pull enable
    input wire logic chip_reset_n, // Device reset pin
    input wire logic interface_select_strap, // Mode strap
    input wire rci_pkg::rci_pwr_type power_state, // Power state
    input wire logic two_wire_mode, // Latched mode
    input wire logic cmd_busy // Command executing
);
    int unsigned busy_n;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // Length of the current busy stretch
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_n <= 0;
        end else begin
            busy_n <= cmd_busy ? busy_n + 1 : 0;
        end
    end
    drive_low_a: assert property (sda_out == 1'b0)
        else $error("data drive value not low");
    mode_gate_a: assert property (!two_wire_mode |-> !sda_oe)
        else $error("data driven outside two-wire mode");
    mode_track_a: assert property (($stable(interface_select_strap) &&
        power_state == rci_pkg::PS_RESET) [*8] |->
        two_wire_mode == interface_select_strap)
        else $error("mode does not follow strap");
    mode_frozen_a: assert property (power_state != rci_pkg::PS_RESET &&
        $past(power_state) != rci_pkg::PS_RESET |->
        $stable(two_wire_mode))
        else $error("mode changed outside reset");
    state_onehot_a: assert property ($onehot(power_state))
        else $error("power state not one-hot");
    pin_reset_a: assert property (!chip_reset_n [*8] |->
        power_state == rci_pkg::PS_RESET && !cmd_busy)
        else $error("reset pin low but not in reset");
    reset_quiet_a: assert property ((power_state == rci_pkg::PS_RESET) [*3]
        |-> !sda_oe)
        else $error("data driven in reset");
    startup_entry_a: assert property ($rose(power_state ==
        rci_pkg::PS_STARTUP) |-> $past(power_state) == rci_pkg::PS_RESET
        && chip_reset_n)
        else $error("startup not entered from reset");
    oper_entry_a: assert property ($rose(power_state == rci_pkg::PS_OPER)
        |-> $past(power_state) == rci_pkg::PS_STARTUP)
        else $error("operational not entered from startup");
    busy_min_a: assert property ($rose(cmd_busy) |-> cmd_busy [*8])
        else $error("command finished too soon");
    busy_max_a: assert property (busy_n <= LAUNCH_DAB_CYC + 2)
        else $error("command ran too long");
endmodule
bind rci_port rci_port_sva #(.LAUNCH_DAB_CYC(LAUNCH_DAB_CYC)) sva (
    .core_clk(core_clk),
    .rstn(rstn),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .chip_reset_n(chip_reset_n),
    .interface_select_strap(interface_select_strap),
    .power_state(power_state),
    .two_wire_mode(two_wire_mode),
    .cmd_busy(cmd_busy)
);
`default_nettype wire

// File: testbench/rci_host.sv
// Host controller model acting as two-wire master
`timescale 1ns/1ps
`default_nettype none
module rci_host (
    output logic scl, // Serial clock, high and still between frames
    output logic host_oe, // Pulls data low when high
    input wire logic sda // Resolved data wire
);
    localparam time HALF = 24ns;
    // Idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        host_oe = 1'b0;
    end
    // Data falls while clock high
    task automatic start();
        host_oe = 1'b1;
        #HALF scl = 1'b0;
        // Extra low time so the port leaves link reset before bit one
        #HALF;
    endtask
    // One clock pulse, data taken at the rising edge
    task automatic pulse(output logic v);
        #(HALF - 5ns) scl = 1'b1;
        v = sda;
        #HALF scl = 1'b0;
    endtask
    // Eight bits MSB first, then the device's acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            #5ns host_oe = ~b[i];
            pulse(v);
        end
        #5ns host_oe = 1'b0;
        pulse(v);
        ack = ~v;
    endtask
    // Eight bits in, then acknowledge or not
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic v;
        #5ns host_oe = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(v);
            b[i] = v;
            #5ns;
        end
        host_oe = ack;
        pulse(v);
    endtask
    // Data rises while clock high
    task automatic stop();
        #5ns host_oe = 1'b1;
        #(HALF - 5ns) scl = 1'b1;
        #HALF host_oe = 1'b0;
        #HALF;
    endtask
endmodule
`default_nettype wire

// File: testbench/rci_port_bench.sv
// Self-checking bench for the two-wire command port
`timescale 1ns/1ps
`default_nettype none
module rci_port_bench;
    localparam int unsigned WFM = 20;
    localparam int unsigned LDAB = 900;
    localparam logic [6:0] AD = {rci_pkg::ADDR_FIXED, 2'h0};
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic chip_reset_n = 1'b0;
    logic strap = 1'b1;
    logic ss_n = 1'b0;
    logic miso = 1'b0;
    logic dig = 1'b0;
    logic scl, host_oe, sda_oe, sda_out, two_wire_mode, cmd_busy;
    rci_pkg::rci_pwr_type power_state;
    wire sda;
    int error_cnt = 0;
    int compares = 0;
    logic [7:0] rb [5];
    // Open-drain wire with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & ~host_oe;
    always #2.5 core_clk = ~core_clk;
    rci_port #(.WAKE_FM_CYC(WFM), .WAKE_DAB_CYC(24), .LAUNCH_FM_CYC(40),
        .LAUNCH_DAB_CYC(LDAB)) uut (
        .core_clk(core_clk),
        .rstn(rstn),
        .scl_clk(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .chip_reset_n(chip_reset_n),
        .interface_select_strap(strap),
        .slave_select_pin_n(ss_n),
        .miso_strap_in(miso),
        .digital_mode(dig),
        .power_state(power_state),
        .two_wire_mode(two_wire_mode),
        .cmd_busy(cmd_busy)
    );
    rci_host host (.scl(scl), .host_oe(host_oe), .sda(sda));
    task automatic summarize();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Pulse the reset pin with new straps
    task automatic boot(input logic s, input logic a1, input logic a0);
        @(posedge core_clk);
        chip_reset_n <= 1'b0;
        strap <= s;
        ss_n <= a1;
        miso <= a0;
        cyc(10);
        chk(power_state === rci_pkg::PS_RESET, "no reset");
        chip_reset_n <= 1'b1;
        cyc(20);
        chk(power_state === rci_pkg::PS_STARTUP, "no startup");
    endtask
    task automatic probe(input logic [6:0] ad, input logic exp);
        logic a;
        host.start();
        host.wbyte({ad, 1'b1}, a);
        host.stop();
        chk(a === exp, "address ack");
    endtask
    task automatic wr(input logic [7:0] op, input int n);
        logic a;
        host.start();
        host.wbyte({AD, 1'b0}, a);
        chk(a === 1'b1, "ctl ack");
        host.wbyte(op, a);
        chk(a === 1'b1, "op ack");
        for (int i = 0; i < n; i++) begin
            host.wbyte(8'(i), a);
            chk(a === 1'b1, "arg ack");
        end
        host.stop();
    endtask
    // Read five bytes, refuse the last
    task automatic rd();
        logic a;
        host.start();
        host.wbyte({AD, 1'b1}, a);
        chk(a === 1'b1, "read ack");
        for (int i = 0; i < 5; i++) begin
            host.rbyte(i < 4, rb[i]);
        end
        host.stop();
        chk(rb[4] === 8'h00, "past response");
    endtask
    task automatic wait_idle(output int k);
        k = 0;
        while (cmd_busy === 1'b1 && k < 3000) begin
            cyc(1);
            k++;
        end
        if (k == 3000) begin
            chk(1'b0, "busy hang");
            summarize();
        end
    endtask
    task automatic t_reset();
        cyc(10);
        chk(power_state === rci_pkg::PS_RESET, "reset state");
        probe(AD, 1'b0);
        boot(1'b1, 1'b0, 1'b0);
        $display("t_reset done");
    endtask
    task automatic t_wake();
        int k;
        wr(rci_pkg::OP_WAKE, 2);
        cyc(8);
        chk(cmd_busy === 1'b1, "busy start");
        wait_idle(k);
        chk(k + 10 >= WFM && k <= WFM, "wake time");
        rd();
        chk(rb[0] === 8'h80, "status");
        chk(rb[1] === {5'h0, rci_pkg::PS_STARTUP}, "state");
        chk(rb[2] === rci_pkg::OP_WAKE, "command");
        chk(rb[3] === 8'h02, "arg count");
        wr(rci_pkg::OP_LOAD, 3);
        cyc(8);
        wait_idle(k);
        rd();
        chk(rb[0] === 8'h80, "load status");
        chk(rb[2] === rci_pkg::OP_LOAD, "load command");
        chk(rb[3] === 8'h03, "load args");
        wr(8'h33, 0);
        cyc(8);
        wait_idle(k);
        rd();
        chk(rb[0] === 8'hc0, "startup refuse");
        chk(rb[1] === {5'h0, rci_pkg::PS_STARTUP}, "still startup");
        $display("t_wake done");
    endtask
    task automatic t_launch();
        int k;
        logic a;
        @(posedge core_clk);
        dig <= 1'b1;
        wr(rci_pkg::OP_LAUNCH, 0);
        rd();
        chk(rb[0][7] === 1'b0, "cts while busy");
        host.start();
        host.wbyte({AD, 1'b0}, a);
        host.wbyte(8'h33, a);
        host.stop();
        wait_idle(k);
        chk(power_state === rci_pkg::PS_OPER, "not operational");
        rd();
        chk(rb[0] === 8'h80, "status");
        chk(rb[1] === {5'h0, rci_pkg::PS_OPER}, "state");
        chk(rb[2] === rci_pkg::OP_LAUNCH, "busy write kept");
        wr(rci_pkg::OP_WAKE, 0);
        cyc(8);
        wait_idle(k);
        rd();
        chk(rb[0] === 8'hc0, "wake error");
        $display("t_launch done");
    endtask
    task automatic t_addr();
        for (int i = 0; i < 4; i++) begin
            boot(1'b1, i[1], i[0]);
            chk(two_wire_mode === 1'b1, "mode");
            probe({rci_pkg::ADDR_FIXED, i[1:0]}, 1'b1);
            probe({rci_pkg::ADDR_FIXED, ~i[1:0]}, 1'b0);
            probe({~rci_pkg::ADDR_FIXED, i[1:0]}, 1'b0);
        end
        boot(1'b0, 1'b0, 1'b0);
        chk(two_wire_mode === 1'b0, "mode");
        probe(AD, 1'b0);
        $display("t_addr done");
    endtask
    initial begin
        cyc(2);
        rstn <= 1'b1;
        t_reset();
        t_wake();
        t_launch();
        t_addr();
        summarize();
    end
endmodule
`default_nettype wire
